// [rtl/pulse_capture_consts.vh]
`ifndef PULSE_CAPTURE_CONSTS_VH
`define PULSE_CAPTURE_CONSTS_VH
`define OFS_MODE 5'h00
`define OFS_TIMER 5'h04
`define OFS_START 5'h08
`define OFS_IRQ_STATUS 5'h0C
`define OFS_IRQ_MASK 5'h10
`define OFS_PRESCALE 5'h14
`define MODE_SEL0_BIT 0
`define MODE_SEL1_BIT 1
`define MODE_EDGE_BIT 2
`define MODE_WIDTH_BIT 3
`define MODE_OVF_BIT 5
`define MODE_CLK_LO_BIT 6
`define MODE_CLK_HI_BIT 7
`define MODE_RESET 8'h00
`define PRESCALE_RESET 8'h00
`define DIV_F2 3'd1
`define DIV_F16 3'd4
`define DIV_F64 3'd6
`define IRQ_CAPTURE_BIT 0
`define IRQ_OVF_BIT 1
`endif

// [rtl/count_clock_divider.v]
`include "pulse_capture_consts.vh"
module count_clock_divider (
   input wire clk,
   input wire arst_n,
   input wire [1:0] clk_sel,
   output reg tick
);
   reg [5:0] div_q;
   reg [5:0] mask;
   always @* begin
      case (clk_sel)
         2'h0: mask = 6'h01;
         2'h1: mask = 6'h07;
         2'h2: mask = 6'h0F;
         default: mask = 6'h3F;
      endcase
   end
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         div_q <= 6'h00;
         tick <= 1'b0;
      end else begin
         div_q <= div_q + 6'h01;
         tick <= ((div_q & mask) == mask);
      end
   end
endmodule

// [rtl/pulse_period_width_capture.v]
// Functional notes
// - Measure only when mode bits read 10
// - Mode bits 7:6 choose count clock
// - Counter advances only while start flag set
// - Bit 3 zero measures input period
// - Bit 2 picks falling or rising edges
// - Edge copies count, clears, restarts counting
// - Each capture but the first raises interrupt request bit
// - First capture after start raises nothing
// - Bit 3 one measures pulse width
// - Timer read returns captured reload value
// - Counter wrap to zero sets overflow
// - Mode write clears overflow flag unless a wrap comes in the same cycle
`include "pulse_capture_consts.vh"
module pulse_period_width_capture (
   input wire clk,
   input wire arst_n,
   input wire measure_input_pin,
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [31:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output wire irq
);
   reg [7:0] mode_q;
   reg start_q;
   reg [15:0] count_q;
   reg [15:0] reload_q;
   reg first_q;
   reg [1:0] status_q;
   reg [1:0] mask_q;
   reg sync1_q;
   reg sync2_q;
   reg prev_q;
   reg [4:0] aw_addr_q;
   reg aw_have_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   reg w_have_q;
   wire tick;
   wire measuring;
   wire rise;
   wire fall;
   wire edge_hit;
   wire capture;
   wire wrap;
   wire do_write;
   wire mode_wr;
   wire start_wr;
   wire stat_wr;
   wire mask_wr;
   reg [31:0] rd_val;
   reg rd_ok;

   count_clock_divider u_div (
      .clk(clk),
      .arst_n(arst_n),
      .clk_sel(mode_q[`MODE_CLK_HI_BIT:`MODE_CLK_LO_BIT]),
      .tick(tick)
   );

   // Pin is asynchronous to clk
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         sync1_q <= measure_input_pin;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end

   assign rise = sync2_q & ~prev_q;
   assign fall = ~sync2_q & prev_q;
   assign measuring = ~mode_q[`MODE_SEL0_BIT] & mode_q[`MODE_SEL1_BIT];
   // Edge picked by bit 2 in period mode, either edge in width mode
   assign edge_hit = mode_q[`MODE_WIDTH_BIT] ? (rise | fall) :
                     (mode_q[`MODE_EDGE_BIT] ? rise : fall);
   // Edges are seen at clk rate, so short counts still resolve
   assign capture = measuring & start_q & edge_hit;
   assign wrap = measuring & start_q & tick & ~capture & (count_q == 16'hFFFF);

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count_q <= 16'h0000;
         reload_q <= 16'h0000;
         first_q <= 1'b1;
      end else begin
         if (start_wr && !w_data_q[0]) begin
            first_q <= 1'b1;
         end else if (start_wr && w_data_q[0] && !start_q) begin
            first_q <= 1'b1;
         end else if (capture) begin
            first_q <= 1'b0;
         end
         if (capture) begin
            reload_q <= count_q;
            count_q <= 16'h0000;
         end else if (measuring && start_q && tick) begin
            count_q <= count_q + 16'h0001;
         end
      end
   end

   // AXI4-Lite write path: address and data in either order
   assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
   assign s_axi_wready = ~w_have_q & ~s_axi_bvalid;
   assign do_write = aw_have_q & w_have_q & ~s_axi_bvalid;
   assign mode_wr = do_write & (aw_addr_q == `OFS_MODE) & w_strb_q[0];
   assign start_wr = do_write & (aw_addr_q == `OFS_START) & w_strb_q[0];
   assign stat_wr = do_write & (aw_addr_q == `OFS_IRQ_STATUS) & w_strb_q[0];
   assign mask_wr = do_write & (aw_addr_q == `OFS_IRQ_MASK) & w_strb_q[0];

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         aw_addr_q <= 5'h00;
         aw_have_q <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         w_have_q <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_q <= {s_axi_awaddr[4:2], 2'h0};
            aw_have_q <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            w_have_q <= 1'b1;
         end
         if (do_write) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr_q <= `OFS_IRQ_MASK) ? 2'h0 : 2'h2;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mode_q <= `MODE_RESET;
         start_q <= 1'b0;
         status_q <= 2'h0;
         mask_q <= 2'h0;
      end else begin
         if (mode_wr) begin
            mode_q[7:6] <= w_data_q[7:6];
            mode_q[4:0] <= w_data_q[4:0];
         end
         // Overflow set wins over the mode-write clear
         if (wrap) begin
            mode_q[`MODE_OVF_BIT] <= 1'b1;
         end else if (mode_wr) begin
            mode_q[`MODE_OVF_BIT] <= 1'b0;
         end
         if (start_wr) begin
            start_q <= w_data_q[0];
         end
         if (mask_wr) begin
            mask_q <= w_data_q[1:0];
         end
         status_q[`IRQ_CAPTURE_BIT] <= (capture & ~first_q) |
            (status_q[`IRQ_CAPTURE_BIT] & ~(stat_wr & w_data_q[`IRQ_CAPTURE_BIT]));
         status_q[`IRQ_OVF_BIT] <= wrap |
            (status_q[`IRQ_OVF_BIT] & ~(stat_wr & w_data_q[`IRQ_OVF_BIT]));
      end
   end

   assign irq = |(status_q & mask_q);

   // AXI4-Lite read path
   assign s_axi_arready = ~s_axi_rvalid;
   always @* begin
      rd_val = 32'h0000_0000;
      rd_ok = 1'b1;
      case ({s_axi_araddr[4:2], 2'h0})
         `OFS_MODE: rd_val = {24'h000000, mode_q};
         `OFS_TIMER: rd_val = {16'h0000, reload_q};
         `OFS_START: rd_val = {31'h00000000, start_q};
         `OFS_IRQ_STATUS: rd_val = {30'h00000000, status_q};
         `OFS_IRQ_MASK: rd_val = {30'h00000000, mask_q};
         default: rd_ok = 1'b0;
      endcase
      if (s_axi_araddr[31:5] != 27'h0000000) begin
         rd_ok = 1'b0;
         rd_val = 32'h0000_0000;
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

// [testbench/pulse_capture_chk.sv]
module pulse_capture_chk (
   input wire clk,
   input wire arst_n,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] s_axi_rdata,
   input wire irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   a_write_answer: assert property (wr_taken |=> ##1 s_axi_bvalid) else $error("write answer late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
   a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
   a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data moved");
   a_bvalid_ends: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
   a_rvalid_ends: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
   a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw taken during answer");
   a_reset_quiet: assert property ($rose(arst_n) |-> !irq && !s_axi_rvalid) else $error("busy after reset");
endmodule
bind pulse_period_width_capture pulse_capture_chk u_pulse_capture_chk (.clk, .arst_n, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .irq);

// [testbench/sig_src.sv]
module sig_src (
   input wire clk,
   input wire [15:0] half,
   output logic pin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] cnt_q;
   initial pin = 1'b1;
   // Zero half stops edges, so tests never overlap
   always @(posedge clk) begin
      if (half == 16'h0) begin
         cnt_q <= 16'h0;
      end else if (cnt_q >= half - 16'h1) begin
         cnt_q <= 16'h0;
         pin <= ~pin;
      end else begin
         cnt_q <= cnt_q + 16'h1;
      end
   end
endmodule

// [testbench/test_pulse_period_width_capture.sv]
module test_pulse_period_width_capture;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, da, dw;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, rv;
   logic [3:0] s_axi_wstrb;
   logic [15:0] half;
   logic [1:0] rr, rb;
   wire measure_input_pin, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   int n_mismatch = 0, n_tests = 0, cyc = 0;
   int modes[4] = '{8'h02, 8'h46, 8'h8A, 8'hC2};
   int halves[4] = '{20, 80, 160, 640};
   int exps[4] = '{20, 20, 10, 20};
   pulse_period_width_capture u_pulse_period_width_capture (.clk, .arst_n, .measure_input_pin, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .irq);
   sig_src u_sig_src (.clk, .half, .pin(measure_input_pin));
   initial begin
      clk = 0;
      forever #10 clk = ~clk;
   end
   task end_sim;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_mismatch++;
         end_sim;
      end
   end
   task chk(input string nm, input logic [31:0] e, g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask
   task wr(input logic [31:0] a, d);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      da = 0;
      dw = 0;
      while (!(da && dw)) begin
         @(negedge clk);
         da |= s_axi_awvalid && s_axi_awready;
         dw |= s_axi_wvalid && s_axi_wready;
         @(posedge clk);
         if (da) s_axi_awvalid <= 0;
         if (dw) s_axi_wvalid <= 0;
      end
      do @(negedge clk); while (!s_axi_bvalid);
      rb = s_axi_bresp;
      @(posedge clk);
      s_axi_bready <= 0;
   endtask
   task rd(input logic [31:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do @(negedge clk); while (!s_axi_arready);
      @(posedge clk);
      s_axi_arvalid <= 0;
      do @(negedge clk); while (!s_axi_rvalid);
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge clk);
      s_axi_rready <= 0;
   endtask
   task run(input int h);
      half <= h[15:0];
      repeat (8 * h + 40) @(posedge clk);
   endtask
   initial begin
      {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr, half} = 0;
      s_axi_wstrb = 4'hF;
      repeat (6) @(posedge clk);
      arst_n <= 1;
      rd(32'h0);
      chk("mode", 32'h0, rv);
      wr(32'h10, 32'h3);
      wr(32'h0, 32'h2);
      wr(32'h8, 32'h1);
      half <= 16'h14;
      @(negedge measure_input_pin);
      repeat (10) @(posedge clk);
      rd(32'hC);
      chk("first", 32'h0, rv);
      @(negedge measure_input_pin);
      repeat (10) @(posedge clk);
      rd(32'hC);
      chk("status", 32'h1, rv);
      chk("irq", 32'h1, irq);
      wr(32'h10, 32'h0);
      chk("masked", 32'h0, irq);
      $display("capture test done");
      for (int i = 0; i < 4; i++) begin
         wr(32'h0, modes[i]);
         run(halves[i]);
         rd(32'h4);
         chk("timer", 32'h1, rv >= exps[i] - 1 && rv <= exps[i] + 1);
         $display("mode %h test done", modes[i]);
      end
      half <= 16'h0;
      repeat (8) @(posedge clk);
      wr(32'h0, 32'h1);
      chk("bresp ok", 32'h0, rb);
      rd(32'h0);
      chk("mode back", 32'h1, rv);
      wr(32'hC, 32'h3);
      run(20);
      rd(32'hC);
      chk("idle", 32'h0, rv);
      rd(32'h1C);
      chk("resp", 32'h2, rr);
      wr(32'h14, 32'h0);
      chk("bresp err", 32'h2, rb);
      $display("refusal test done");
      end_sim;
   end
endmodule
